// [shared/cpc_pkg.sv]
// Constants for the pump and phase detector configuration bank.
// Assumes a 32-bit Avalon-MM bus with byte addresses; index times four.
package cpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          ADDR_W   = 8;
  localparam int          DATA_W   = 32;
  localparam int          BE_W     = DATA_W / 8;

  // Register indices; byte address is index times four
  localparam logic [5:0]  IDX_ANALOG_EN = 6'h08;
  localparam logic [5:0]  IDX_PUMP      = 6'h09;
  localparam logic [5:0]  IDX_AMP       = 6'h0a;
  localparam logic [5:0]  IDX_DET       = 6'h0b;
  localparam logic [5:0]  IDX_LOCK      = 6'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // Pump register layout
  localparam int          PUMP_W        = 24;
  localparam int          OFS_W         = 3;
  localparam int          TRIM_W        = 4;
  localparam int          MAIN_W        = 3;
  localparam int          RISE_OFS_LSB  = 2;
  localparam int          FALL_OFS_LSB  = 7;
  localparam int          RISE_TRIM_LSB = 10;
  localparam int          FALL_TRIM_LSB = 14;
  localparam int          RISE_MAIN_LSB = 18;
  localparam int          FALL_MAIN_LSB = 21;
  localparam logic [23:0] PUMP_RW_MASK  = 24'hffff9c;
  localparam logic [23:0] PUMP_RST      = 24'h000000;
  localparam logic [2:0]  MAIN_SAT_CODE = 3'h4;

  // Amplifier bias register
  localparam int          AMP_W         = 2;
  localparam logic [1:0]  AMP_RST       = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Detector register layout
  localparam int          DET_W         = 12;
  localparam logic [11:0] DET_RST       = 12'h870;
  localparam int          DLY_LSB       = 0;
  localparam int          DLY_W         = 3;
  localparam int          SWAP_BIT      = 3;
  localparam int          RISE_EN_BIT   = 4;
  localparam int          FALL_EN_BIT   = 5;
  localparam int          LOCKPIN_BIT   = 6;
  localparam int          FORCE_R_BIT   = 7;
  localparam int          FORCE_F_BIT   = 8;
  localparam int          MUTE_BIT      = 9;

  // Analog enable register
  localparam int          ANA_W         = 3;
  localparam logic [2:0]  ANA_RST       = 3'h7;
  localparam int          ANA_PUMP_BIT  = 1;
  localparam int          ANA_DET_BIT   = 2;

endpackage

// [shared/cpc_leg_if.sv]
// Carries one pump direction's codes to its decoder and the results back.
// Assumes both ends run on the bank's single clock.
`timescale 1ns/100ps
interface cpc_leg_if;
  import cpc_pkg::*;

  logic [OFS_W-1:0]  offset_code;
  logic [TRIM_W-1:0] trim_code;
  logic [MAIN_W-1:0] main_code;
  logic              det_enable;
  logic [OFS_W-1:0]  offset_level;
  logic [TRIM_W-1:0] trim_level;
  logic [MAIN_W-1:0] main_level;
  logic              hiz;

  modport ctl (
    output offset_code, trim_code, main_code, det_enable,
    input  offset_level, trim_level, main_level, hiz
  );
  modport leg (
    input  offset_code, trim_code, main_code, det_enable,
    output offset_level, trim_level, main_level, hiz
  );
endinterface

// [design/cpc_pump_leg.sv]
// Decodes the codes of one pump direction into registered levels.
// Assumes codes come from the register bank on the same clock.
`timescale 1ns/100ps
module cpc_pump_leg
  import cpc_pkg::*;
(
  // Clock and reset
  input  wire logic CLK_I,
  input  wire logic RST_N_I,
  // Codes in, levels out
  cpc_leg_if.leg    leg
);

  ////////////////////////////////////////////////////////////////////////////
  // offset steps pass through
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      leg.offset_level <= '0;
      leg.trim_level   <= '0;
    end else begin
      leg.offset_level <= leg.offset_code;
      leg.trim_level   <= leg.trim_code;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      leg.main_level <= '0;
    end else if (leg.main_code >= MAIN_SAT_CODE) begin
      leg.main_level <= MAIN_SAT_CODE;
    end else begin
      leg.main_level <= leg.main_code;
    end
  end

  // float when off and detector off
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      leg.hiz <= 1'b0;
    end else begin
      leg.hiz <= (leg.main_code == '0) && !leg.det_enable;
    end
  end

endmodule // cpc_pump_leg

// [design/cpc_top.sv]
// Configuration bank for the pump and phase detector, Avalon-MM slave.
// Assumes synchronous inputs on CLK_I at 200 MHz; analog parts outside.
`timescale 1ns/100ps

// Function
// - rise offset code from pump bits 4:2
// - fall offset code from pump bits 9:7
// - rise trim code from pump bits 13:10
// - fall trim code from pump bits 17:14
// - main codes decode, saturating at 100
// - main code 000, detector off: float
// - amplifier bias code from bits 1:0
// - amplifier enabled only with pump enable
// - reset path delay from detector bits 2:0
// - detector bit 3 swaps detector inputs
// - detector bit 4 enables rise output
// - detector bit 5 enables fall output
// - detector bit 6 routes lock to pin
// - mute bit gates enables only while locked
module cpc_top
  import cpc_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] ADDRESS_I,
  input  wire logic              READ_I,
  input  wire logic              WRITE_I,
  input  wire logic [DATA_W-1:0] WRITEDATA_I,
  input  wire logic [BE_W-1:0]   BYTEENABLE_I,
  output logic      [DATA_W-1:0] READDATA_O,
  output logic                   WAITREQUEST_O,
  // Detector inputs and lock flag
  input  wire logic              DET_REF_I,
  input  wire logic              DET_DIV_I,
  input  wire logic              LOCK_I,
  // Rise pump settings
  output logic      [OFS_W-1:0]  PUMP_RISE_OFFSET_CODE_O,
  output logic      [TRIM_W-1:0] PUMP_RISE_TRIM_CODE_O,
  output logic      [MAIN_W-1:0] PUMP_RISE_MAIN_CODE_O,
  output logic                   PUMP_RISE_HIZ_O,
  // Fall pump settings
  output logic      [OFS_W-1:0]  PUMP_FALL_OFFSET_CODE_O,
  output logic      [TRIM_W-1:0] PUMP_FALL_TRIM_CODE_O,
  output logic      [MAIN_W-1:0] PUMP_FALL_MAIN_CODE_O,
  output logic                   PUMP_FALL_HIZ_O,
  // Amplifier
  output logic      [AMP_W-1:0]  AMPLIFIER_BIAS_CODE_O,
  output logic                   AMPLIFIER_ENABLE_O,
  // Detector controls
  output logic      [DLY_W-1:0]  DET_RESET_DELAY_O,
  output logic                   DET_FIRST_O,
  output logic                   DET_SECOND_O,
  output logic                   DET_RISE_ALLOW_O,
  output logic                   DET_FALL_ALLOW_O,
  output logic                   DET_RISE_FORCE_O,
  output logic                   DET_FALL_FORCE_O,
  // Shared lock and readback pin
  output logic                   LOCK_READBACK_PIN_O,
  output logic                   LOCK_READBACK_OE_N_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [PUMP_W-1:0] pump_r;
  logic [AMP_W-1:0]  amp_r;
  logic [DET_W-1:0]  det_r;
  logic [ANA_W-1:0]  ana_r;
  logic              locked_r;
  logic              waitreq_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] be_mask;
  logic [5:0]        idx;
  logic              req;
  logic              commit_wr;
  logic              hit;

  cpc_leg_if rise_leg ();
  cpc_leg_if fall_leg ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign idx       = ADDRESS_I[ADDR_W-1:2];
  assign req       = READ_I || WRITE_I;
  assign commit_wr = WRITE_I && !waitreq_r;

  always_comb begin
    be_mask = '0;
    for (int b = 0; b < BE_W; b++) begin
      be_mask[b*8 +: 8] = {8{BYTEENABLE_I[b]}};
    end
  end

  // Waitrequest drops for one cycle per request, so the master never
  // completes two transfers on one decode.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      waitreq_r <= 1'b1;
    end else if (req && waitreq_r) begin
      waitreq_r <= 1'b0;
    end else begin
      waitreq_r <= 1'b1;
    end
  end

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    rdata_nxt = '0;
    hit       = 1'b1;
    unique case (idx)
      IDX_ANALOG_EN: rdata_nxt[ANA_W-1:0]  = ana_r;
      IDX_PUMP:      rdata_nxt[PUMP_W-1:0] = pump_r;
      IDX_AMP:       rdata_nxt[AMP_W-1:0]  = amp_r;
      IDX_DET:       rdata_nxt[DET_W-1:0]  = det_r;
      IDX_LOCK:      rdata_nxt[0]          = locked_r;
      default:       hit                   = 1'b0;
    endcase
  end

  // Read data is captured one edge early and held to the next read
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rdata_r <= '0;
    end else if (READ_I && waitreq_r) begin
      rdata_r <= hit ? rdata_nxt : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers and the sampled lock flag
  // reserved pump bits stay zero
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pump_r <= PUMP_RST;
    end else if (commit_wr && idx == IDX_PUMP) begin
      pump_r <= ((pump_r & ~be_mask[PUMP_W-1:0])
                | (WRITEDATA_I[PUMP_W-1:0] & be_mask[PUMP_W-1:0]))
                & PUMP_RW_MASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      amp_r <= AMP_RST;
    end else if (commit_wr && idx == IDX_AMP && BYTEENABLE_I[0]) begin
      amp_r <= WRITEDATA_I[AMP_W-1:0];
    end
  end

  // delay field held in detector register
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      det_r <= DET_RST;
    end else if (commit_wr && idx == IDX_DET) begin
      det_r <= (det_r & ~be_mask[DET_W-1:0])
               | (WRITEDATA_I[DET_W-1:0] & be_mask[DET_W-1:0]);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ana_r <= ANA_RST;
    end else if (commit_wr && idx == IDX_ANALOG_EN && BYTEENABLE_I[0]) begin
      ana_r <= WRITEDATA_I[ANA_W-1:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      locked_r <= 1'b0;
    end else begin
      locked_r <= LOCK_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pump legs
  // rise offset field
  assign rise_leg.offset_code = pump_r[RISE_OFS_LSB +: OFS_W];
  assign rise_leg.trim_code   = pump_r[RISE_TRIM_LSB +: TRIM_W];
  assign rise_leg.main_code   = pump_r[RISE_MAIN_LSB +: MAIN_W];
  assign rise_leg.det_enable  = ana_r[ANA_DET_BIT];

  assign fall_leg.offset_code = pump_r[FALL_OFS_LSB +: OFS_W];
  assign fall_leg.trim_code   = pump_r[FALL_TRIM_LSB +: TRIM_W];
  assign fall_leg.main_code   = pump_r[FALL_MAIN_LSB +: MAIN_W];
  assign fall_leg.det_enable  = ana_r[ANA_DET_BIT];

  cpc_pump_leg u_rise (
    .CLK_I   (CLK_I),
    .RST_N_I (RST_N_I),
    .leg     (rise_leg.leg)
  );

  cpc_pump_leg u_fall (
    .CLK_I   (CLK_I),
    .RST_N_I (RST_N_I),
    .leg     (fall_leg.leg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Amplifier and delay outputs
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      AMPLIFIER_BIAS_CODE_O <= AMP_RST;
      AMPLIFIER_ENABLE_O    <= 1'b0;
      DET_RESET_DELAY_O     <= DET_RST[DLY_LSB +: DLY_W];
    end else begin
      AMPLIFIER_BIAS_CODE_O <= amp_r;
      AMPLIFIER_ENABLE_O    <= ana_r[ANA_PUMP_BIT];
      DET_RESET_DELAY_O     <= det_r[DLY_LSB +: DLY_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector input order
  // swap for negative slope
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DET_FIRST_O  <= 1'b0;
      DET_SECOND_O <= 1'b0;
    end else if (det_r[SWAP_BIT]) begin
      DET_FIRST_O  <= DET_DIV_I;
      DET_SECOND_O <= DET_REF_I;
    end else begin
      DET_FIRST_O  <= DET_REF_I;
      DET_SECOND_O <= DET_DIV_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector output gating
  // Mute mode frees both outputs while unlocked so acquisition is not
  // starved; the enables only bite once lock is reached.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DET_RISE_ALLOW_O <= 1'b1;
      DET_FALL_ALLOW_O <= 1'b1;
    end else if (det_r[MUTE_BIT] && !locked_r) begin
      DET_RISE_ALLOW_O <= 1'b1;
      DET_FALL_ALLOW_O <= 1'b1;
    end else begin
      DET_RISE_ALLOW_O <= det_r[RISE_EN_BIT];
      DET_FALL_ALLOW_O <= det_r[FALL_EN_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      DET_RISE_FORCE_O <= 1'b0;
      DET_FALL_FORCE_O <= 1'b0;
    end else begin
      DET_RISE_FORCE_O <= det_r[FORCE_R_BIT];
      DET_FALL_FORCE_O <= det_r[FORCE_F_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock pin
  // route lock flag when enabled
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LOCK_READBACK_PIN_O  <= 1'b0;
      LOCK_READBACK_OE_N_O <= 1'b1;
    end else begin
      LOCK_READBACK_PIN_O  <= det_r[LOCKPIN_BIT] && locked_r;
      LOCK_READBACK_OE_N_O <= !det_r[LOCKPIN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flops
  assign READDATA_O              = rdata_r;
  assign WAITREQUEST_O           = waitreq_r;
  assign PUMP_RISE_OFFSET_CODE_O = rise_leg.offset_level;
  assign PUMP_RISE_TRIM_CODE_O   = rise_leg.trim_level;
  assign PUMP_RISE_MAIN_CODE_O   = rise_leg.main_level;
  assign PUMP_RISE_HIZ_O         = rise_leg.hiz;
  assign PUMP_FALL_OFFSET_CODE_O = fall_leg.offset_level;
  assign PUMP_FALL_TRIM_CODE_O   = fall_leg.trim_level;
  assign PUMP_FALL_MAIN_CODE_O   = fall_leg.main_level;
  assign PUMP_FALL_HIZ_O         = fall_leg.hiz;

endmodule // cpc_top

// [verif/cpc_props.sv]
// Concurrent checks on the ports of the pump and detector bank.
// Assumes a bind to cpc_top; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module cpc_props
  import cpc_pkg::*;
(
  // Clock, reset and bus handshake
  input wire logic              CLK_I,
  input wire logic              RST_N_I,
  input wire logic              READ_I,
  input wire logic              WRITE_I,
  input wire logic              WAITREQUEST_O,
  // Detector inputs and lock flag
  input wire logic              DET_REF_I,
  input wire logic              DET_DIV_I,
  input wire logic              LOCK_I,
  // Decoded outputs
  input wire logic [OFS_W-1:0]  PUMP_RISE_OFFSET_CODE_O,
  input wire logic [MAIN_W-1:0] PUMP_RISE_MAIN_CODE_O,
  input wire logic [MAIN_W-1:0] PUMP_FALL_MAIN_CODE_O,
  input wire logic              PUMP_RISE_HIZ_O,
  input wire logic [DLY_W-1:0]  DET_RESET_DELAY_O,
  input wire logic              DET_FIRST_O,
  input wire logic              DET_SECOND_O,
  input wire logic              LOCK_READBACK_PIN_O,
  input wire logic              LOCK_READBACK_OE_N_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // A write completes at the edge that sees waitrequest low
  logic wr_done;
  assign wr_done = WRITE_I && !WAITREQUEST_O;

  ////////////////////////////////////////////////////////////////////////////
  property p_wait_once;
    !WAITREQUEST_O |=> WAITREQUEST_O;
  endproperty
  a_wait_once: assert property (p_wait_once)
    else $error("waitrequest low for more than one cycle");

  property p_wait_answer;
    (READ_I || WRITE_I) && WAITREQUEST_O |=> !WAITREQUEST_O;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("request not answered in one cycle");

  property p_main_sat;
    PUMP_RISE_MAIN_CODE_O <= MAIN_SAT_CODE &&
      PUMP_FALL_MAIN_CODE_O <= MAIN_SAT_CODE;
  endproperty
  a_main_sat: assert property (p_main_sat)
    else $error("main level above saturation");

  property p_hiz_zero;
    PUMP_RISE_HIZ_O |-> PUMP_RISE_MAIN_CODE_O == 3'h0;
  endproperty
  a_hiz_zero: assert property (p_hiz_zero)
    else $error("pump floated with nonzero main code");

  property p_det_pass;
    $past(RST_N_I) |->
      {DET_FIRST_O, DET_SECOND_O} == {$past(DET_REF_I), $past(DET_DIV_I)} ||
      {DET_FIRST_O, DET_SECOND_O} == {$past(DET_DIV_I), $past(DET_REF_I)};
  endproperty
  a_det_pass: assert property (p_det_pass)
    else $error("detector outputs not the inputs one cycle late");

  property p_pin_off;
    LOCK_READBACK_OE_N_O |-> !LOCK_READBACK_PIN_O;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("lock pin high while not driven");

  property p_pin_follow;
    !LOCK_READBACK_OE_N_O && !$past(LOCK_READBACK_OE_N_O) |->
      LOCK_READBACK_PIN_O == $past(LOCK_I, 2);
  endproperty
  a_pin_follow: assert property (p_pin_follow)
    else $error("lock pin does not follow lock flag");

  // Pump codes pass the register and the leg, so two or three edges
  property p_ofs_quiet;
    $changed(PUMP_RISE_OFFSET_CODE_O) |-> $past(wr_done, 2) ||
      $past(wr_done, 3);
  endproperty
  a_ofs_quiet: assert property (p_ofs_quiet)
    else $error("offset code changed without a write");

  property p_dly_quiet;
    $changed(DET_RESET_DELAY_O) |-> $past(wr_done, 2);
  endproperty
  a_dly_quiet: assert property (p_dly_quiet)
    else $error("reset delay changed without a write");

  c_write: cover property (wr_done);
  c_hiz: cover property (PUMP_RISE_HIZ_O);
  c_pin: cover property ($fell(LOCK_READBACK_OE_N_O));
endmodule // cpc_props

// [verif/cpc_host_model.sv]
// Host model: Avalon-MM master writing and reading the bank registers.
// Assumes the slave answers by waitrequest; the bench owns the timeout.
`timescale 1ns/100ps
module cpc_host_model
  import cpc_pkg::*;
(
  // Clock and slave answer
  input  wire logic              clk_i,
  input  wire logic [DATA_W-1:0] readdata_i,
  input  wire logic              waitrequest_i,
  // Master request
  output logic      [ADDR_W-1:0] address_o,
  output logic                   read_o,
  output logic                   write_o,
  output logic      [DATA_W-1:0] writedata_o,
  output logic      [BE_W-1:0]   byteenable_o
);
  initial begin
    address_o = '0;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = '0;
    byteenable_o = '1;
  end

  task automatic wr(input logic [5:0] idx, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = d;
    if (idx == IDX_PUMP) v = d & {8'h00, PUMP_RW_MASK};
    @(posedge clk_i);
    address_o <= {idx, 2'b00};
    writedata_o <= v;
    write_o <= 1'b1;
    do @(posedge clk_i); while (waitrequest_i !== 1'b0);
    write_o <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    address_o <= {idx, 2'b00};
    read_o <= 1'b1;
    do @(posedge clk_i); while (waitrequest_i !== 1'b0);
    d = readdata_i;
    read_o <= 1'b0;
  endtask
endmodule // cpc_host_model

// [verif/pll_charge_pump_pfd_config_bench.sv]
// Self-checking bench for the pump and detector configuration bank.
// Assumes cpc_props and cpc_host_model are compiled before this file.
`timescale 1ns/100ps
module pll_charge_pump_pfd_config_bench;
  import cpc_pkg::*;
  logic              clk, rst_n, ref_in, div_in, lock_in, rd_en, wr_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rdata, wdata, rv;
  logic [BE_W-1:0]   be;
  logic              wreq, r_hiz, f_hiz, amp_en, first, second, pin, oe_n;
  logic              r_allow, f_allow, r_force, f_force;
  logic [OFS_W-1:0]  r_ofs, f_ofs;
  logic [TRIM_W-1:0] r_trim, f_trim;
  logic [MAIN_W-1:0] r_main, f_main;
  logic [AMP_W-1:0]  bias;
  logic [DLY_W-1:0]  dly;
  logic [2:0]        kk, nk;
  logic [23:0]       w;
  int                bad_count, n_tests;
  // Main code in, decoded level out, one row per code
  localparam logic [2:0] MAIN_EXP [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                          3'h4, 3'h4, 3'h4, 3'h4};

  cpc_top cpc_top_i (.CLK_I(clk), .RST_N_I(rst_n), .ADDRESS_I(addr),
    .READ_I(rd_en), .WRITE_I(wr_en), .WRITEDATA_I(wdata),
    .BYTEENABLE_I(be), .READDATA_O(rdata), .WAITREQUEST_O(wreq),
    .DET_REF_I(ref_in), .DET_DIV_I(div_in), .LOCK_I(lock_in),
    .PUMP_RISE_OFFSET_CODE_O(r_ofs), .PUMP_RISE_TRIM_CODE_O(r_trim),
    .PUMP_RISE_MAIN_CODE_O(r_main), .PUMP_RISE_HIZ_O(r_hiz),
    .PUMP_FALL_OFFSET_CODE_O(f_ofs), .PUMP_FALL_TRIM_CODE_O(f_trim),
    .PUMP_FALL_MAIN_CODE_O(f_main), .PUMP_FALL_HIZ_O(f_hiz),
    .AMPLIFIER_BIAS_CODE_O(bias), .AMPLIFIER_ENABLE_O(amp_en),
    .DET_RESET_DELAY_O(dly), .DET_FIRST_O(first), .DET_SECOND_O(second),
    .DET_RISE_ALLOW_O(r_allow), .DET_FALL_ALLOW_O(f_allow),
    .DET_RISE_FORCE_O(r_force), .DET_FALL_FORCE_O(f_force),
    .LOCK_READBACK_PIN_O(pin), .LOCK_READBACK_OE_N_O(oe_n));

  cpc_host_model cpc_host_model_i (.clk_i(clk), .readdata_i(rdata),
    .waitrequest_i(wreq), .address_o(addr), .read_o(rd_en),
    .write_o(wr_en), .writedata_o(wdata), .byteenable_o(be));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Outputs settle one edge after a write completes; waits n edges, then 1 ns
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ref_in = 1'b0;
    div_in = 1'b0;
    lock_in = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
    cpc_host_model_i.rd(IDX_DET, rv);
    chk(rv, 32'h870);
    cpc_host_model_i.rd(IDX_PUMP, rv);
    chk(rv, 32'h0);
    chk({r_allow, f_allow, oe_n, amp_en}, 4'b1101);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      kk = 3'(k);
      nk = ~kk;
      w = {nk, kk, kk, 1'b1, nk, 1'b0, nk, 2'b00, kk, 2'b00};
      cpc_host_model_i.wr(IDX_PUMP, {8'h00, w});
      settle(3);
      chk(r_ofs, kk);
      chk(f_ofs, nk);
      chk(r_trim, {nk, 1'b0});
      chk(f_trim, {kk, 1'b1});
      chk(r_main, MAIN_EXP[k]);
      chk(f_main, MAIN_EXP[7-k]);
      cpc_host_model_i.rd(IDX_PUMP, rv);
      chk(rv, {8'h00, w});
    end
    $display("test pump rows done");
    cpc_host_model_i.wr(IDX_ANALOG_EN, 32'h3);
    settle(3);
    chk({r_hiz, f_hiz, amp_en}, 3'b011);
    cpc_host_model_i.wr(IDX_ANALOG_EN, 32'h5);
    settle(3);
    chk({f_hiz, amp_en}, 2'b00);
    cpc_host_model_i.wr(IDX_AMP, 32'h3);
    settle(3);
    chk(bias, 2'h3);
    cpc_host_model_i.rd(6'h05, rv);
    chk(rv, 32'h0);
    $display("test analog done");
    @(posedge clk);
    ref_in <= 1'b1;
    cpc_host_model_i.wr(IDX_DET, 32'h872);
    settle(3);
    chk({dly, first, second}, 5'b01010);
    // Delay kept at 010 from here on, as software is advised to
    cpc_host_model_i.wr(IDX_DET, 32'h87a);
    settle(3);
    chk({first, second}, 2'b01);
    cpc_host_model_i.wr(IDX_DET, 32'h802);
    settle(3);
    chk({r_allow, f_allow, oe_n, pin}, 4'b0010);
    cpc_host_model_i.wr(IDX_DET, 32'ha02);
    settle(3);
    chk({r_allow, f_allow}, 2'b11);
    @(posedge clk);
    lock_in <= 1'b1;
    settle(3);
    chk({r_allow, f_allow}, 2'b00);
    cpc_host_model_i.rd(IDX_LOCK, rv);
    chk(rv, 32'h1);
    cpc_host_model_i.wr(IDX_DET, 32'ha12);
    settle(3);
    chk({r_allow, f_allow}, 2'b10);
    cpc_host_model_i.wr(IDX_DET, 32'h9f2);
    settle(3);
    chk({pin, oe_n, r_force, f_force}, 4'b1011);
    $display("test detector done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);
    cpc_host_model_i.rd(IDX_AMP, rv);
    chk(rv, 32'h0);
    $display("test second reset done");
    stop_test();
  end
endmodule // pll_charge_pump_pfd_config_bench

bind cpc_top cpc_props cpc_props_i (
  .CLK_I, .RST_N_I, .READ_I, .WRITE_I, .WAITREQUEST_O, .DET_REF_I,
  .DET_DIV_I, .LOCK_I, .PUMP_RISE_OFFSET_CODE_O, .PUMP_RISE_MAIN_CODE_O,
  .PUMP_FALL_MAIN_CODE_O, .PUMP_RISE_HIZ_O, .DET_RESET_DELAY_O,
  .DET_FIRST_O, .DET_SECOND_O, .LOCK_READBACK_PIN_O, .LOCK_READBACK_OE_N_O);
